// ===== rtl/ccc_pkg.sv
// Shared constants for the charger cycle controller
package ccc_pkg;

	// ----------------------------------------------------------------
	// Clock and filter timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int INRANGE_RISE_MS = 50;
	localparam int INRANGE_FALL_US = 2;
	localparam int CMP_FILTER_MS = 400;
	localparam int TIMEOUT_STEP_MIN = 10;
	localparam int INRANGE_RISE_CYCLES =
		int'((64'(INRANGE_RISE_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1) /
		64'(CLK_PERIOD_PS));
	localparam int INRANGE_FALL_CYCLES =
		(INRANGE_FALL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CMP_FILTER_CYCLES =
		int'((64'(CMP_FILTER_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1) /
		64'(CLK_PERIOD_PS));
	localparam logic [47:0] TIMEOUT_STEP_CYCLES =
		48'((64'(TIMEOUT_STEP_MIN) * 64'd60000000000000) / 64'(CLK_PERIOD_PS));

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PRECHARGE_SETTINGS_ADDR = 8'h82;
	localparam logic [7:0] CHARGER_STATUS_ADDR = 8'h83;
	localparam logic [7:0] PRECHARGE_SETTINGS_RESET = 8'h00;
	localparam int PRE_CUR_LSB = 0;
	localparam int PRE_FULLRATE_LSB = 2;
	localparam int PRE_TIME_LSB = 5;
	localparam logic [1:0] PRE_CUR_OFF = 2'h0;
	localparam logic [2:0] TIMEOUT_DISABLED = 3'h0;
	localparam logic [2:0] UPPER_LIMIT_DISABLED = 3'h7;

	typedef enum logic [2:0] {
		CCC_IDLE,
		CCC_PRECHARGE,
		CCC_FULLRATE,
		CCC_CONST_VOLT,
		CCC_STANDBY,
		CCC_FAULT
	} ccc_state_t;

endpackage

// ===== rtl/ccc_deglitch.sv
// Two-flop synchroniser followed by an edge-dependent deglitch filter
`timescale 1ns/10ps
module ccc_deglitch #(
	parameter int unsigned RISE_CYCLES = 1,
	parameter int unsigned FALL_CYCLES = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Raw level and filtered result
	input wire logic rawIn,
	output logic filtered
);
	typedef struct packed {
		logic syncA;
		logic syncB;
		logic level;
		logic [31:0] count;
	} ccc_flt_t;

	ccc_flt_t cur;
	ccc_flt_t next_cur;
	logic [31:0] limit;

	always_comb begin
		next_cur = cur;
		next_cur.syncA = rawIn;
		next_cur.syncB = cur.syncA;
		limit = cur.level ? 32'(FALL_CYCLES) : 32'(RISE_CYCLES);
		// A change must hold for the full time; any bounce restarts the count
		if (cur.syncB == cur.level) begin
			next_cur.count = 32'h0;
		end else if (cur.count + 32'h1 >= limit) begin
			next_cur.level = cur.syncB;
			next_cur.count = 32'h0;
		end else begin
			next_cur.count = cur.count + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign filtered = cur.level;
endmodule // ccc_deglitch

// ===== rtl/ccc_charger_ctrl.sv
// Charger cycle controller: input qualification, power routing and charge sequencing
//
// Behaviour
// - Charger operates only while input is above lower and, unless upper check is disabled, below upper threshold.
// - Lower threshold tracks battery plus offset, optional absolute minimum check.
// - Upper threshold has seven levels or a disabled setting.
// - Total input current limited to the input current limit code.
// - High current mode ignores the input current limit.
// - Status pin, when selected, is low while input is in range.
// - System supply on while input in range, except standby with supply off.
// - System branch has priority; battery current is reduced near the limit.
// - System reaching input limit turns the routing switch on.
// - After overload switch-on, system limit uses the battery limit code.
// - Limit disable bit lets the system draw without switching on.
// - With switch on, cycle decisions continue but do not drive charging.
// - Standby supply on: rail fed from battery through switch.
// - Standby supply off: rail isolated except in high current mode; system branch disabled.
// - Valid input starts precharge; zero current field disables precharge current.
// - Precharge settings live at 0x82 and persist while powered.
// - Battery at full-rate level moves precharge to full-rate charging.
// - Precharge beyond its time limit isolates battery and stops charging.
// - Termination voltage moves to constant voltage with end-of-charge watch.
// - End-of-charge disables battery branch and enters standby.
// - Full-charge timeout ends charging to standby; restart reinitiates the cycle.
// - End-of-charge needs current below level for the full filter time.
// - Restart needs battery below restart level for the full filter time.
// - Full-rate, restart and end-of-charge comparators deglitched for 400 ms.
// - Input-in-range deglitched 50 ms rising, 2 us falling.
`timescale 1ns/10ps
module ccc_charger_ctrl
	import ccc_pkg::*;
#(
	parameter int unsigned INRANGE_RISE = ccc_pkg::INRANGE_RISE_CYCLES,
	parameter int unsigned CMP_FILTER = ccc_pkg::CMP_FILTER_CYCLES,
	parameter logic [47:0] TIMEOUT_STEP = ccc_pkg::TIMEOUT_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// Analog comparator results
	input wire logic inputAboveBattOffset,
	input wire logic inputAboveAbsMin,
	input wire logic inputBelowUpper,
	input wire logic battAboveFullRate,
	input wire logic battAtTerm,
	input wire logic chargeCurBelowEoc,
	input wire logic battBelowRestart,
	input wire logic systemAtInputLimit,
	input wire logic totalNearInputLimit,
	// Configuration
	input wire logic absMinEnable,
	input wire logic [2:0] upperLimitSel,
	input wire logic [3:0] input_current_limit_code,
	input wire logic [3:0] battery_current_limit_code,
	input wire logic highCurrentMode,
	input wire logic system_limit_disable_bit,
	input wire logic standbySupplyOn,
	input wire logic statusPinSelect,
	input wire logic [2:0] fullTimeoutCode,
	// Analog controls
	output logic [2:0] upperThresholdSel,
	output logic absMinCheck,
	output logic [2:0] fullRateLevelSel,
	output logic [1:0] precharge_current_field,
	output logic inputLimitEnable,
	output logic [3:0] inputLimitCode,
	output logic sysLimitEnable,
	output logic [3:0] sysLimitCode,
	output logic battThrottle,
	output logic battBranchEnable,
	output logic sysSupplyEnable,
	output logic routeSwitchOn,
	// Status
	output logic statusPin,
	output logic inRange,
	output ccc_pkg::ccc_state_t chargeState
);
	import ccc_pkg::*;

	// ----------------------------------------------------------------
	// Comparator synchronising and filtering
	// ----------------------------------------------------------------
	logic lowerOk;
	logic absMinOk;
	logic upperOk;
	logic rangeRaw;
	logic fullRateOk;
	logic termReached;
	logic eocOk;
	logic restartOk;
	logic sysOverload;
	logic nearLimit;

	ccc_deglitch #(.RISE_CYCLES(1), .FALL_CYCLES(1)) uLower (
		.clk(clk), .resetn(resetn), .rawIn(inputAboveBattOffset), .filtered(lowerOk));
	ccc_deglitch #(.RISE_CYCLES(1), .FALL_CYCLES(1)) uAbsMin (
		.clk(clk), .resetn(resetn), .rawIn(inputAboveAbsMin), .filtered(absMinOk));
	ccc_deglitch #(.RISE_CYCLES(1), .FALL_CYCLES(1)) uUpper (
		.clk(clk), .resetn(resetn), .rawIn(inputBelowUpper), .filtered(upperOk));
	ccc_deglitch #(.RISE_CYCLES(1), .FALL_CYCLES(1)) uTerm (
		.clk(clk), .resetn(resetn), .rawIn(battAtTerm), .filtered(termReached));
	ccc_deglitch #(.RISE_CYCLES(1), .FALL_CYCLES(1)) uOverload (
		.clk(clk), .resetn(resetn), .rawIn(systemAtInputLimit), .filtered(sysOverload));
	ccc_deglitch #(.RISE_CYCLES(1), .FALL_CYCLES(1)) uNear (
		.clk(clk), .resetn(resetn), .rawIn(totalNearInputLimit), .filtered(nearLimit));

	assign rangeRaw = lowerOk && (!absMinEnable || absMinOk) &&
		(upperLimitSel == UPPER_LIMIT_DISABLED || upperOk);

	ccc_deglitch #(.RISE_CYCLES(INRANGE_RISE), .FALL_CYCLES(INRANGE_FALL_CYCLES)) uRange (
		.clk(clk), .resetn(resetn), .rawIn(rangeRaw), .filtered(inRange));
	ccc_deglitch #(.RISE_CYCLES(CMP_FILTER), .FALL_CYCLES(CMP_FILTER)) uFullRate (
		.clk(clk), .resetn(resetn), .rawIn(battAboveFullRate), .filtered(fullRateOk));
	ccc_deglitch #(.RISE_CYCLES(CMP_FILTER), .FALL_CYCLES(CMP_FILTER)) uEoc (
		.clk(clk), .resetn(resetn), .rawIn(chargeCurBelowEoc), .filtered(eocOk));
	ccc_deglitch #(.RISE_CYCLES(CMP_FILTER), .FALL_CYCLES(CMP_FILTER)) uRestart (
		.clk(clk), .resetn(resetn), .rawIn(battBelowRestart), .filtered(restartOk));

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ccc_state_t state;
		logic [7:0] preSettings;
		logic [47:0] preTimer;
		logic [47:0] fullTimer;
		logic overload;
		logic cycleDone;
		logic [7:0] rdata;
	} ccc_ctrl_t;

	ccc_ctrl_t cur;
	ccc_ctrl_t next_cur;
	logic [2:0] preTimeCode;
	logic [47:0] preLimit;
	logic [47:0] fullLimit;
	logic preExpired;
	logic fullExpired;
	logic standby;

	assign preTimeCode = cur.preSettings[PRE_TIME_LSB +: 3];
	assign preLimit = 48'(TIMEOUT_STEP * 48'(preTimeCode));
	assign fullLimit = 48'(TIMEOUT_STEP * 48'(fullTimeoutCode));
	assign preExpired = preTimeCode != TIMEOUT_DISABLED && cur.preTimer >= preLimit;
	assign fullExpired = fullTimeoutCode != TIMEOUT_DISABLED && cur.fullTimer >= fullLimit;
	assign standby = cur.state == CCC_STANDBY;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		if (regWrite && regAddr == PRECHARGE_SETTINGS_ADDR) begin
			next_cur.preSettings = regWdata;
		end
		if (regAddr == PRECHARGE_SETTINGS_ADDR) begin
			next_cur.rdata = cur.preSettings;
		end else if (regAddr == CHARGER_STATUS_ADDR) begin
			next_cur.rdata = {cur.cycleDone, cur.overload, routeSwitchOn, inRange, 1'b0,
				cur.state};
		end else begin
			next_cur.rdata = 8'h00;
		end

		// The overload latch only clears on standby entry or loss of input
		if (inRange && sysOverload && !system_limit_disable_bit && !highCurrentMode &&
				!standby) begin
			next_cur.overload = 1'b1;
		end

		if (!inRange) begin
			next_cur.state = CCC_IDLE;
			next_cur.preTimer = 48'h0;
			next_cur.fullTimer = 48'h0;
			next_cur.overload = 1'b0;
			next_cur.cycleDone = 1'b0;
		end else begin
			unique case (cur.state)
				CCC_IDLE: begin
					next_cur.state = CCC_PRECHARGE;
					next_cur.preTimer = 48'h0;
				end
				CCC_PRECHARGE: begin
					next_cur.preTimer = cur.preTimer + 48'h1;
					if (fullRateOk) begin
						next_cur.state = CCC_FULLRATE;
						next_cur.fullTimer = 48'h0;
					end else if (preExpired) begin
						next_cur.state = CCC_FAULT;
					end
				end
				CCC_FULLRATE: begin
					next_cur.fullTimer = cur.fullTimer + 48'h1;
					if (fullExpired) begin
						next_cur.state = CCC_STANDBY;
						next_cur.cycleDone = 1'b1;
						next_cur.overload = 1'b0;
					end else if (termReached) begin
						next_cur.state = CCC_CONST_VOLT;
					end
				end
				CCC_CONST_VOLT: begin
					next_cur.fullTimer = cur.fullTimer + 48'h1;
					if (eocOk || fullExpired) begin
						next_cur.state = CCC_STANDBY;
						next_cur.cycleDone = 1'b1;
						next_cur.overload = 1'b0;
					end
				end
				CCC_STANDBY: begin
					if (cur.cycleDone && restartOk) begin
						next_cur.state = CCC_PRECHARGE;
						next_cur.preTimer = 48'h0;
						next_cur.fullTimer = 48'h0;
					end
				end
				CCC_FAULT: begin
					// Stays isolated until the input goes away
					next_cur.state = CCC_FAULT;
				end
				default: begin
					next_cur.state = CCC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur.state <= CCC_IDLE;
			cur.preSettings <= PRECHARGE_SETTINGS_RESET;
			cur.preTimer <= 48'h0;
			cur.fullTimer <= 48'h0;
			cur.overload <= 1'b0;
			cur.cycleDone <= 1'b0;
			cur.rdata <= 8'h00;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic charging;

	assign chargeState = cur.state;
	assign regRdata = cur.rdata;
	assign upperThresholdSel = upperLimitSel;
	assign absMinCheck = absMinEnable;
	assign fullRateLevelSel = cur.preSettings[PRE_FULLRATE_LSB +: 3];
	assign precharge_current_field = cur.preSettings[PRE_CUR_LSB +: 2];

	assign inputLimitEnable = !highCurrentMode;
	assign inputLimitCode = input_current_limit_code;
	assign sysLimitEnable = !highCurrentMode && !system_limit_disable_bit;
	assign sysLimitCode = cur.overload ? battery_current_limit_code : input_current_limit_code;

	// No input, overload, high current mode or standby with supply kept on
	assign routeSwitchOn = !inRange || highCurrentMode ||
		(standby ? standbySupplyOn : cur.overload);

	// Cycle keeps running while the switch is on but only gates the branch here
	assign charging = (cur.state == CCC_PRECHARGE && precharge_current_field != PRE_CUR_OFF) ||
		cur.state == CCC_FULLRATE || cur.state == CCC_CONST_VOLT;
	assign battBranchEnable = inRange && charging && !routeSwitchOn;
	assign battThrottle = battBranchEnable && nearLimit && inputLimitEnable;
	assign sysSupplyEnable = inRange && !(standby && !standbySupplyOn);
	assign statusPin = statusPinSelect ? !inRange : 1'b1;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_RANGE_IDLE: assert property (@(posedge clk) disable iff (!resetn)
		!inRange |=> chargeState == CCC_IDLE && !battBranchEnable)
		else $error("sequencer not idle after input loss");

	AST_STATUS_PIN: assert property (@(posedge clk) disable iff (!resetn)
		statusPinSelect |-> statusPin != inRange)
		else $error("status pin does not follow input range");

	AST_PRE_ENTRY: assert property (@(posedge clk) disable iff (!resetn)
		chargeState == CCC_IDLE && inRange |=> chargeState == CCC_PRECHARGE)
		else $error("precharge not entered on valid input");

	AST_PRE_TIMEOUT: assert property (@(posedge clk) disable iff (!resetn)
		chargeState == CCC_PRECHARGE && inRange && !fullRateOk && preExpired
		|=> chargeState == CCC_FAULT ##1 !battBranchEnable)
		else $error("precharge timeout did not isolate battery");

	AST_SYS_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
		$rose(cur.overload) |-> sysLimitCode == battery_current_limit_code && routeSwitchOn)
		else $error("system limit not moved to battery code");

	AST_SWITCH_NO_CHG: assert property (@(posedge clk) disable iff (!resetn)
		routeSwitchOn |-> !battBranchEnable)
		else $error("battery branch on with routing switch on");

	// Loss of input or high current mode turn the switch on whatever the standby option
	AST_STANDBY_OFF: assert property (@(posedge clk) disable iff (!resetn)
		chargeState == CCC_STANDBY && !standbySupplyOn && inRange && !highCurrentMode
		|-> !sysSupplyEnable && !routeSwitchOn)
		else $error("standby supply off not honoured");

	AST_SWITCH_DECIDE: assert property (@(posedge clk) disable iff (!resetn)
		routeSwitchOn && inRange && chargeState == CCC_CONST_VOLT && eocOk
		|=> chargeState == CCC_STANDBY)
		else $error("cycle decision lost while routing switch on");

	AST_RESTART: assert property (@(posedge clk) disable iff (!resetn)
		chargeState == CCC_STANDBY && inRange && restartOk |=> chargeState == CCC_PRECHARGE)
		else $error("restart did not reinitiate the cycle");

	AST_EOC: assert property (@(posedge clk) disable iff (!resetn)
		chargeState == CCC_CONST_VOLT && inRange && eocOk
		|=> chargeState == CCC_STANDBY && !battBranchEnable)
		else $error("end of charge did not reach standby");

	AST_HC_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
		highCurrentMode |-> !inputLimitEnable && !battThrottle)
		else $error("input limit active in high current mode");

	AST_TIMER_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
		!inRange |=> cur.preTimer == 48'h0 && cur.fullTimer == 48'h0)
		else $error("timeout counters not cleared");
endmodule // ccc_charger_ctrl

// ===== bench/ccc_supply_model.sv
// Adapter and battery model that feeds the comparator results of the charger controller
`timescale 1ns/10ps
module ccc_supply_model (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Scenario controls
	input wire logic adapterOn,
	input wire logic adapterHigh,
	input wire logic drain,
	input wire logic eocLow,
	// Charger controls
	input wire logic battBranchEnable,
	input wire logic [2:0] fullRateLevelSel,
	// Comparator results
	output logic inputAboveBattOffset,
	output logic inputAboveAbsMin,
	output logic inputBelowUpper,
	output logic battAboveFullRate,
	output logic battAtTerm,
	output logic chargeCurBelowEoc,
	output logic battBelowRestart
);
	// ----------------------------------------------------------------
	// Battery charge level
	// ----------------------------------------------------------------
	// A load drains faster than the charger fills, so a restart is reached quickly
	int level = 0;

	always @(posedge clk) begin
		if (!resetn) begin
			level <= 0;
		end else if (drain) begin
			level <= (level > 4) ? level - 4 : 0;
		end else if (battBranchEnable) begin
			level <= level + 1;
		end
	end

	assign inputAboveBattOffset = adapterOn;
	assign inputAboveAbsMin = adapterOn;
	assign inputBelowUpper = !adapterHigh;
	assign battAboveFullRate = level >= 64 + 64 * int'(fullRateLevelSel);
	assign battAtTerm = level >= 600;
	assign chargeCurBelowEoc = eocLow;
	assign battBelowRestart = level < 500;
endmodule // ccc_supply_model

// ===== bench/test_charger_cycle_control.sv
// Self-checking testbench for the charger cycle controller
`timescale 1ns/10ps
module test_charger_cycle_control;
	import ccc_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk = 0, resetn = 0, regWrite = 0, absMinEnable = 0, highCurrentMode = 0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
	logic systemAtInputLimit = 0, totalNearInputLimit = 0, system_limit_disable_bit = 0;
	logic standbySupplyOn = 1, statusPinSelect = 1, adapterOn = 0, adapterHigh = 0;
	logic drain = 0, eocLow = 0;
	logic [2:0] upperLimitSel = 3'h0, fullTimeoutCode = 3'h0, upperThresholdSel, fullRateLevelSel;
	// Input limit kept well above the battery limit
	logic [3:0] inCode = 4'h9, batCode = 4'h4;
	logic [3:0] inputLimitCode, sysLimitCode;
	logic [1:0] precharge_current_field;
	logic inputAboveBattOffset, inputAboveAbsMin, inputBelowUpper, battAboveFullRate, battAtTerm;
	logic chargeCurBelowEoc, battBelowRestart, absMinCheck, inputLimitEnable, sysLimitEnable;
	logic battThrottle, battBranchEnable, sysSupplyEnable, routeSwitchOn, statusPin, inRange;
	ccc_state_t chargeState;
	int fails = 0, n_checks = 0;

	always #2 clk = ~clk;

	ccc_charger_ctrl #(.INRANGE_RISE(20), .CMP_FILTER(10), .TIMEOUT_STEP(48'd100))
		ccc_charger_ctrl_i (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite),
		.regWdata(regWdata), .regRdata(regRdata), .inputAboveBattOffset(inputAboveBattOffset),
		.inputAboveAbsMin(inputAboveAbsMin), .inputBelowUpper(inputBelowUpper),
		.battAboveFullRate(battAboveFullRate), .battAtTerm(battAtTerm),
		.chargeCurBelowEoc(chargeCurBelowEoc), .battBelowRestart(battBelowRestart),
		.systemAtInputLimit(systemAtInputLimit), .totalNearInputLimit(totalNearInputLimit),
		.absMinEnable(absMinEnable), .upperLimitSel(upperLimitSel),
		.input_current_limit_code(inCode), .battery_current_limit_code(batCode),
		.highCurrentMode(highCurrentMode), .system_limit_disable_bit(system_limit_disable_bit),
		.standbySupplyOn(standbySupplyOn), .statusPinSelect(statusPinSelect),
		.fullTimeoutCode(fullTimeoutCode), .upperThresholdSel(upperThresholdSel),
		.absMinCheck(absMinCheck), .fullRateLevelSel(fullRateLevelSel),
		.precharge_current_field(precharge_current_field), .inputLimitEnable(inputLimitEnable),
		.inputLimitCode(inputLimitCode), .sysLimitEnable(sysLimitEnable),
		.sysLimitCode(sysLimitCode), .battThrottle(battThrottle),
		.battBranchEnable(battBranchEnable), .sysSupplyEnable(sysSupplyEnable),
		.routeSwitchOn(routeSwitchOn), .statusPin(statusPin), .inRange(inRange),
		.chargeState(chargeState));

	ccc_supply_model ccc_supply_model_i (.clk(clk), .resetn(resetn), .adapterOn(adapterOn),
		.adapterHigh(adapterHigh), .drain(drain), .eocLow(eocLow),
		.battBranchEnable(battBranchEnable), .fullRateLevelSel(fullRateLevelSel),
		.inputAboveBattOffset(inputAboveBattOffset), .inputAboveAbsMin(inputAboveAbsMin),
		.inputBelowUpper(inputBelowUpper), .battAboveFullRate(battAboveFullRate),
		.battAtTerm(battAtTerm), .chargeCurBelowEoc(chargeCurBelowEoc),
		.battBelowRestart(battBelowRestart));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1;
		@(negedge clk);
		regWrite = 0;
		// One idle cycle keeps the strobe from toggling twice in a time step
		@(negedge clk);
	endtask

	// Read data lands one edge after the address, so two falling edges pass
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		regAddr = a;
		repeat (2) @(negedge clk);
		check(regRdata, exp);
	endtask

	task automatic waitSt(input ccc_state_t s, input int maxCyc);
		int i;
		for (i = 0; i < maxCyc && chargeState !== s; i++) begin
			@(negedge clk);
		end
		check(8'(chargeState), 8'(s));
		if (chargeState !== s) begin
			conclude();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(negedge clk);
		resetn = 1;
		@(negedge clk);
		check(8'(chargeState), 8'(CCC_IDLE));
		check({routeSwitchOn, sysSupplyEnable, battBranchEnable, statusPin}, 8'h09);
		rd(8'h82, 8'h00);
		wr(8'h82, 8'h3d);
		wr(8'h83, 8'hff);
		rd(8'h90, 8'h00);
		rd(8'h82, 8'h3d);
		check({fullRateLevelSel, 3'h0, precharge_current_field}, 8'he1);
		// Full-rate level out of reach, so the precharge timer expires
		adapterOn = 1;
		waitSt(CCC_PRECHARGE, 200);
		check({statusPin, sysSupplyEnable, routeSwitchOn, battBranchEnable}, 8'h05);
		waitSt(CCC_FAULT, 300);
		check(8'(battBranchEnable), 8'h00);
		adapterOn = 0;
		waitSt(CCC_IDLE, 700);
		check({inRange, routeSwitchOn, statusPin}, 8'h03);
		drain = 1;
		repeat (60) @(negedge clk);
		drain = 0;
		wr(8'h82, 8'h05);
		rd(8'h82, 8'h05);
		adapterOn = 1;
		waitSt(CCC_PRECHARGE, 200);
		waitSt(CCC_FULLRATE, 400);
		waitSt(CCC_CONST_VOLT, 900);
		totalNearInputLimit = 1;
		repeat (10) @(negedge clk);
		check(8'(battThrottle), 8'h01);
		totalNearInputLimit = 0;
		systemAtInputLimit = 1;
		repeat (8) @(negedge clk);
		check({routeSwitchOn, battBranchEnable, sysLimitCode}, {2'h0, 2'h2, batCode});
		check(8'(chargeState), 8'(CCC_CONST_VOLT));
		systemAtInputLimit = 0;
		system_limit_disable_bit = 1;
		highCurrentMode = 1;
		upperLimitSel = 3'h5;
		absMinEnable = 1;
		@(negedge clk);
		check({sysLimitEnable, inputLimitEnable, 2'h0, inputLimitCode}, 8'h09);
		check({absMinCheck, 4'h0, upperThresholdSel}, 8'h85);
		system_limit_disable_bit = 0;
		highCurrentMode = 0;
		upperLimitSel = 3'h0;
		absMinEnable = 0;
		eocLow = 1;
		waitSt(CCC_STANDBY, 100);
		check({battBranchEnable, routeSwitchOn, sysSupplyEnable}, 8'h03);
		standbySupplyOn = 0;
		@(negedge clk);
		check({routeSwitchOn, sysSupplyEnable}, 8'h00);
		standbySupplyOn = 1;
		eocLow = 0;
		fullTimeoutCode = 3'h1;
		drain = 1;
		waitSt(CCC_PRECHARGE, 300);
		drain = 0;
		waitSt(CCC_FULLRATE, 100);
		waitSt(CCC_STANDBY, 300);
		check(8'(battAtTerm), 8'h00);
		// Upper check disabled: an over-range adapter is still accepted
		upperLimitSel = 3'h7;
		adapterHigh = 1;
		repeat (600) @(negedge clk);
		check(8'(inRange), 8'h01);
		upperLimitSel = 3'h0;
		waitSt(CCC_IDLE, 700);
		check({inRange, statusPin}, 8'h01);
		statusPinSelect = 0;
		@(negedge clk);
		check(8'(statusPin), 8'h01);
		conclude();
	end
endmodule // test_charger_cycle_control
